// ---- core/mmef_core.sv ----
// monitor message error flag classifier with register port
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "mmef_params.svh"

// Overview of operation
// - bad manchester, bit count, parity sets word flag
// - gap check on, rt pair status response under 4us
// - rt pair status word invalid sets gsa flag
// - rt pair status address mismatch sets gsa
// - second word flag only for rt pairs
// - second command receive bit sets cw2 flag
// - second command mode subaddress sets cw2 flag
// - second command same address sets cw2 flag
// - second command sync error sets cw2 flag
// - broadcast transmit non-mode command is content error
// - receive mode code 0..15 is content error
// - broadcast transmit mode code 0..15 content error
// - two contiguous commands mark rt pair message
// - good block only for error-free messages
module mmef_core (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  // decoded bus words
  input  wire logic               i_word_vld,
  input  wire mmef_pkg::mmef_word_t i_word,
  input  wire logic               i_sync_det,
  input  wire logic               i_msg_end,
  // register port
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic [15:0]        i_reg_wdata,
  output logic      [15:0]        o_reg_rdata,
  // message results
  output logic                    o_msg_done,
  output logic      [15:0]        o_msg_status,
  output logic                    o_irq
);

  // ------------------------------------------------------------
  // state and helpers
  // ------------------------------------------------------------
  mmef_pkg::mmef_regs_t r;        // registered state
  mmef_pkg::mmef_regs_t n;        // next state
  mmef_pkg::mmef_req_t  req;      // bundled register port request
  mmef_pkg::mmef_cmd_t  wc;       // current word as command
  mmef_pkg::mmef_cmd_t  c1;       // first command
  mmef_pkg::mmef_cmd_t  c2;       // second command
  logic                 w_bad;    // invalid word
  logic                 w_cont;   // content error in word
  logic                 w_mode;   // mode command
  logic                 contig;   // word follows without gap
  logic [1:0]           irq_set;  // events this cycle

  assign req = '{wr: i_reg_wr, rd: i_reg_rd, addr: i_reg_addr,
                 wdata: i_reg_wdata};
  assign wc  = mmef_pkg::mmef_cmd_t'(i_word.data);
  assign c1  = mmef_pkg::mmef_cmd_t'(r.cmd1);
  assign c2  = mmef_pkg::mmef_cmd_t'(r.cmd2);

  // invalid word: manchester, bit count or parity
  assign w_bad = i_word.manch_err | i_word.bitcnt_err
               | i_word.par_err;
  assign w_mode = (wc.sa == `MMEF_SA_MODE_LO)
                | (wc.sa == `MMEF_SA_MODE_HI);
  // content checks on any command word
  assign w_cont =
      ((wc.addr == `MMEF_BCAST_ADDR) & wc.tx & ~w_mode)
    | (~wc.tx & w_mode & ~wc.wc[4])
    | ((wc.addr == `MMEF_BCAST_ADDR) & wc.tx & w_mode
       & ~wc.wc[4]);
  // contiguous means the sync came within the no-gap bound
  assign contig = (r.gap_lat <= 9'(`MMEF_CONTIG_MAX_CYC));

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    n       = r;
    n.done  = 1'b0;
    n.rdata = 16'h0000;
    irq_set = 2'h0;

    // response timer, one at each word's mid-parity so the latched
    // value is the whole mid-parity to mid-sync count, not one short
    if (i_word_vld) begin
      n.gap_cnt = 9'h001;
    end else if (r.gap_cnt != `MMEF_GAP_MAX) begin
      n.gap_cnt = r.gap_cnt + 9'h001;
    end
    // latch mid-parity to mid-sync time of the next word
    if (i_sync_det) begin
      n.gap_lat = r.gap_cnt;
    end

    case (r.st)
      // idle bus: a clean command word opens a message
      mmef_pkg::MMEF_IDLE: begin
        if (i_word_vld & i_word.cmd_sync & ~w_bad
            & ~i_word.sync_err) begin
          n.flags  = 4'h0;
          n.is_pair = 1'b0;
          n.n_stat = 2'h0;
          n.cmd1   = i_word.data;
          n.flags[`MMEF_ST_CONT_BIT] = w_cont;
          n.st     = mmef_pkg::MMEF_CMD1;
        end
      end
      // one command seen: a contiguous command makes a pair
      mmef_pkg::MMEF_CMD1: begin
        if (i_word_vld) begin
          n.st = mmef_pkg::MMEF_BODY;
          if (contig & (i_word.cmd_sync | i_word.sync_err)) begin
            n.is_pair = 1'b1;
            n.cmd2  = i_word.data;
            n.flags[`MMEF_ST_WORD_BIT] = r.flags[3] | w_bad;
            n.flags[`MMEF_ST_CONT_BIT] = r.flags[0] | w_cont;
            // cw2 checks only ever run on this path
            if (~wc.tx | w_mode | (wc.addr == c1.addr)
                | i_word.sync_err) begin
              n.flags[`MMEF_ST_CW2_BIT] = 1'b1;
            end
          end else begin
            n.flags[`MMEF_ST_WORD_BIT] = r.flags[3] | w_bad;
          end
        end
      end
      // data and status words
      mmef_pkg::MMEF_BODY: begin
        if (i_word_vld) begin
          n.flags[`MMEF_ST_WORD_BIT] = r.flags[3] | w_bad;
          if (i_word.cmd_sync | i_word.sync_err) begin
            n.n_stat = (r.n_stat == 2'h3) ? r.n_stat
                                          : r.n_stat + 2'h1;
            if (r.is_pair) begin
              // short response, only with gap check enabled
              if (r.cfg_gap & i_word.cmd_sync
                  & (r.gap_lat < 9'(`MMEF_RESP_MIN_CYC))) begin
                n.flags[`MMEF_ST_GSA_BIT] = 1'b1;
              end
              // damaged status word from either terminal
              if (w_bad | i_word.sync_err) begin
                n.flags[`MMEF_ST_GSA_BIT] = 1'b1;
              end
              // transmitter answers first, then receiver
              if ((r.n_stat == 2'h0) & (wc.addr != c2.addr)) begin
                n.flags[`MMEF_ST_GSA_BIT] = 1'b1;
              end
              if ((r.n_stat == 2'h1) & (wc.addr != c1.addr)) begin
                n.flags[`MMEF_ST_GSA_BIT] = 1'b1;
              end
            end
          end
        end
      end
      default: begin
        n.st = mmef_pkg::MMEF_IDLE;
      end
    endcase

    // message completion stores the accumulated flags
    if (i_msg_end & (r.st != mmef_pkg::MMEF_IDLE)) begin
      n.last = 16'h0000;
      n.last[3:0] = n.flags;
      n.last[`MMEF_ST_PAIR_BIT] = n.is_pair;
      n.last[`MMEF_ST_GOOD_BIT] = (n.flags == 4'h0);
      n.done = 1'b1;
      n.st   = mmef_pkg::MMEF_IDLE;
      irq_set[`MMEF_IRQ_DONE_BIT] = 1'b1;
      irq_set[`MMEF_IRQ_ERR_BIT]  = (n.flags != 4'h0);
    end

    // register writes
    if (req.wr) begin
      case (req.addr)
        `MMEF_OFS_CFG:     n.cfg_gap = req.wdata[`MMEF_CFG_GAP_BIT];
        `MMEF_OFS_IRQ_EN:  n.irq_en  = req.wdata[1:0];
        default:           n.cfg_gap = n.cfg_gap;
      endcase
    end
    // sticky status: a new event wins over a clear
    n.irq_stat = r.irq_stat;
    if (req.wr & (req.addr == `MMEF_OFS_IRQ_CLR)) begin
      n.irq_stat = r.irq_stat & ~req.wdata[1:0];
    end
    n.irq_stat = n.irq_stat | irq_set;

    // register reads, data valid one cycle later only
    if (req.rd) begin
      case (req.addr)
        `MMEF_OFS_CFG:      n.rdata[`MMEF_CFG_GAP_BIT] = r.cfg_gap;
        `MMEF_OFS_LAST:     n.rdata = r.last;
        `MMEF_OFS_IRQ_STAT: n.rdata = {14'h0000, r.irq_stat};
        `MMEF_OFS_IRQ_EN:   n.rdata = {14'h0000, r.irq_en};
        default:            n.rdata = 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r          <= '0;
      r.st       <= mmef_pkg::MMEF_IDLE;
      r.gap_cnt  <= `MMEF_GAP_MAX;
      r.gap_lat  <= `MMEF_GAP_MAX;
      r.cfg_gap  <= `MMEF_RST_CFG;
      r.irq_stat <= `MMEF_RST_IRQ;
      r.irq_en   <= `MMEF_RST_IRQ;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_reg_rdata  = r.rdata;
  assign o_msg_done   = r.done;
  assign o_msg_status = r.last;
  assign o_irq        = |(r.irq_stat & r.irq_en);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // a bad word in an open message sets the word error flag next cycle
  a_word_err_flag: assert property (
    (r.st != mmef_pkg::MMEF_IDLE) & i_word_vld & w_bad
    |=> r.flags[`MMEF_ST_WORD_BIT])
    else $error("invalid word not flagged");

  // short response in a pair with gap check sets gsa
  a_gap_short_flag: assert property (
    (r.st == mmef_pkg::MMEF_BODY) & r.is_pair & r.cfg_gap & i_word_vld
    & i_word.cmd_sync & (r.gap_lat < 9'(`MMEF_RESP_MIN_CYC))
    |=> r.flags[`MMEF_ST_GSA_BIT])
    else $error("short rt pair response not flagged");

  // without pair the gsa flag never rises
  a_gsa_pair_only: assert property (
    $rose(r.flags[`MMEF_ST_GSA_BIT]) |-> r.is_pair)
    else $error("gsa flag outside rt pair");

  // cw2 flag only with rt pair marked
  a_cw2_pair_only: assert property (
    $rose(r.flags[`MMEF_ST_CW2_BIT]) |-> r.is_pair)
    else $error("cw2 flag outside rt pair");

  // second command with receive bit flags cw2
  a_cw2_rx_bit: assert property (
    (r.st == mmef_pkg::MMEF_CMD1) & i_word_vld & contig
    & i_word.cmd_sync & ~wc.tx
    |=> r.is_pair & r.flags[`MMEF_ST_CW2_BIT])
    else $error("receive second command not flagged");

  // mode subaddress in the second command flags cw2
  a_cw2_mode_sa: assert property (
    (r.st == mmef_pkg::MMEF_CMD1) & i_word_vld & contig
    & i_word.cmd_sync & w_mode
    |=> r.is_pair & r.flags[`MMEF_ST_CW2_BIT])
    else $error("mode second command not flagged");

  // second command aimed at the receiver flags cw2
  a_cw2_same_addr: assert property (
    (r.st == mmef_pkg::MMEF_CMD1) & i_word_vld & contig
    & i_word.cmd_sync & (wc.addr == c1.addr)
    |=> r.is_pair & r.flags[`MMEF_ST_CW2_BIT])
    else $error("same address second command not flagged");

  // sync error on the second command flags cw2
  a_cw2_sync_err: assert property (
    (r.st == mmef_pkg::MMEF_CMD1) & i_word_vld & contig
    & i_word.sync_err
    |=> r.is_pair & r.flags[`MMEF_ST_CW2_BIT])
    else $error("second command sync error not flagged");

  // broadcast transmit non-mode command flags content
  a_content_bcast: assert property (
    (r.st == mmef_pkg::MMEF_IDLE) & i_word_vld & i_word.cmd_sync
    & ~w_bad & ~i_word.sync_err & (wc.addr == `MMEF_BCAST_ADDR)
    & wc.tx & ~w_mode
    |=> r.flags[`MMEF_ST_CONT_BIT])
    else $error("broadcast transmit not flagged");

  // good block matches flags at the stored word
  a_good_block: assert property (
    o_msg_done |-> (o_msg_status[`MMEF_ST_GOOD_BIT]
                    == (o_msg_status[3:0] == 4'h0)))
    else $error("good block mismatch");

  // new message begins with clear flags
  a_start_clear: assert property (
    (r.st == mmef_pkg::MMEF_IDLE) & i_word_vld & i_word.cmd_sync
    & ~w_bad & ~i_word.sync_err & ~w_cont & ~i_msg_end
    |=> (r.flags == 4'h0) & (r.st == mmef_pkg::MMEF_CMD1))
    else $error("flags not cleared at message start");

  // rt pair mark stored at end
  a_pair_stored: assert property (
    r.is_pair & i_msg_end & (r.st != mmef_pkg::MMEF_IDLE)
    |=> o_msg_done & o_msg_status[`MMEF_ST_PAIR_BIT])
    else $error("rt pair mark not stored");

  // damaged status word in a pair sets gsa
  a_gsa_bad_status: assert property (
    (r.st == mmef_pkg::MMEF_BODY) & r.is_pair & i_word_vld
    & (i_word.cmd_sync | i_word.sync_err) & (w_bad | i_word.sync_err)
    |=> r.flags[`MMEF_ST_GSA_BIT])
    else $error("damaged status word not flagged");

  // first status must carry the transmitter address
  a_gsa_addr_tx: assert property (
    (r.st == mmef_pkg::MMEF_BODY) & r.is_pair & i_word_vld
    & i_word.cmd_sync & (r.n_stat == 2'h0) & (wc.addr != c2.addr)
    |=> r.flags[`MMEF_ST_GSA_BIT])
    else $error("status address mismatch not flagged");

  // undefined receive mode code opens with content flag
  a_content_rx_mode: assert property (
    (r.st == mmef_pkg::MMEF_IDLE) & i_word_vld & i_word.cmd_sync
    & ~w_bad & ~i_word.sync_err & ~wc.tx & w_mode & ~wc.wc[4]
    |=> r.flags[`MMEF_ST_CONT_BIT])
    else $error("undefined receive mode code not flagged");

  // undefined broadcast transmit mode code flags content
  a_content_bc_mode: assert property (
    (r.st == mmef_pkg::MMEF_IDLE) & i_word_vld & i_word.cmd_sync
    & ~w_bad & ~i_word.sync_err & (wc.addr == `MMEF_BCAST_ADDR)
    & wc.tx & w_mode & ~wc.wc[4]
    |=> r.flags[`MMEF_ST_CONT_BIT])
    else $error("undefined broadcast mode code not flagged");

  // covers for main scenarios
  c_pair_message: cover property (o_msg_done
                                  & o_msg_status[`MMEF_ST_PAIR_BIT]);
  c_cw2_flagged: cover property (o_msg_done
                                 & o_msg_status[`MMEF_ST_CW2_BIT]);
  c_good_msg:    cover property (o_msg_done
                                 & o_msg_status[`MMEF_ST_GOOD_BIT]);
  c_gsa_flagged: cover property (o_msg_done
                                 & o_msg_status[`MMEF_ST_GSA_BIT]);
  c_irq_raised:  cover property ($rose(o_irq));

endmodule : mmef_core

// ---- core/mmef_params.svh ----
// constants for the monitor message error flag block
`ifndef MMEF_PARAMS_SVH
`define MMEF_PARAMS_SVH
// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define MMEF_CLK_MHZ          50
`define MMEF_RESP_MIN_NS      4000
`define MMEF_RESP_MIN_CYC     (((`MMEF_RESP_MIN_NS*`MMEF_CLK_MHZ)+999)/1000)
`define MMEF_CONTIG_MAX_NS    3000
`define MMEF_CONTIG_MAX_CYC   ((`MMEF_CONTIG_MAX_NS*`MMEF_CLK_MHZ)/1000)
`define MMEF_GAP_MAX          9'h1FF
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define MMEF_OFS_CFG          8'h00
`define MMEF_OFS_LAST         8'h04
`define MMEF_OFS_IRQ_STAT     8'h08
`define MMEF_OFS_IRQ_CLR      8'h0C
`define MMEF_OFS_IRQ_EN       8'h10
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define MMEF_CFG_GAP_BIT      12
`define MMEF_ST_WORD_BIT      3
`define MMEF_ST_GSA_BIT       2
`define MMEF_ST_CW2_BIT       1
`define MMEF_ST_CONT_BIT      0
`define MMEF_ST_GOOD_BIT      8
`define MMEF_ST_PAIR_BIT      11
`define MMEF_IRQ_DONE_BIT     0
`define MMEF_IRQ_ERR_BIT      1
// ------------------------------------------------------------
// command word fields and codes
// ------------------------------------------------------------
`define MMEF_BCAST_ADDR       5'h1F
`define MMEF_SA_MODE_LO       5'h00
`define MMEF_SA_MODE_HI       5'h1F
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define MMEF_RST_CFG          1'h0
`define MMEF_RST_IRQ          2'h0
`endif

// ---- core/mmef_pkg.sv ----
// types for the monitor message error flag block
package mmef_pkg;
  // ------------------------------------------------------------
  // decoded word from the bus receiver
  // ------------------------------------------------------------
  typedef struct packed {
    logic        cmd_sync;   // command/status sync seen
    logic        sync_err;   // sync pattern invalid
    logic        manch_err;  // manchester error in sync or bits
    logic        bitcnt_err; // wrong number of bits
    logic        par_err;    // parity error
    logic [15:0] data;       // word contents
  } mmef_word_t;

  // command word layout
  typedef struct packed {
    logic [4:0] addr;
    logic       tx;
    logic [4:0] sa;
    logic [4:0] wc;
  } mmef_cmd_t;

  // message tracking states, gray along idle-cmd1-body
  typedef enum logic [1:0] {
    MMEF_IDLE = 2'b00,
    MMEF_CMD1 = 2'b01,
    MMEF_BODY = 2'b11
  } mmef_state_t;

  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } mmef_req_t;

  // whole state of the block
  typedef struct packed {
    mmef_state_t st;
    logic [8:0]  gap_cnt;   // cycles since last mid-parity
    logic [8:0]  gap_lat;   // response time of current word
    logic [15:0] cmd1;
    logic [15:0] cmd2;
    logic        is_pair;
    logic [1:0]  n_stat;
    logic [3:0]  flags;
    logic [15:0] last;
    logic        done;
    logic        cfg_gap;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_en;
    logic [15:0] rdata;
  } mmef_regs_t;
endpackage : mmef_pkg

// ---- dv/mmef_bus_model.sv ----
// bus-side model: controller commands and terminal responses
`timescale 1ns/1ps
module mmef_bus_model (
  // clock
  input  wire logic            i_clk,
  // decoded words toward the monitor
  output logic                 o_word_vld,
  output mmef_pkg::mmef_word_t o_word,
  output logic                 o_sync_det,
  output logic                 o_msg_end
);
  // idle bus: no strobes, word lines hold a non-word pattern
  initial begin
    o_word_vld = 1'b0;
    o_word     = '1;
    o_sync_det = 1'b0;
    o_msg_end  = 1'b0;
  end
  // one word; gap runs from the last mid-parity to this mid-sync
  task automatic send(input logic cs, input logic [3:0] e,
                      input logic [15:0] d, input int gap);
    repeat (gap - 1) @(posedge i_clk);
    o_sync_det <= 1'b1;
    @(posedge i_clk);
    o_sync_det <= 1'b0;
    repeat (2) @(posedge i_clk);
    o_word_vld <= 1'b1;
    o_word     <= {cs, e, d};
    @(posedge i_clk);
    o_word_vld <= 1'b0;
    // released: inverse, so a stale word can never look valid
    o_word     <= {~cs, ~e, ~d};
  endtask : send
  // bus falls idle a while after the last word
  task automatic finish_msg();
    repeat (20) @(posedge i_clk);
    o_msg_end <= 1'b1;
    @(posedge i_clk);
    o_msg_end <= 1'b0;
  endtask : finish_msg
endmodule : mmef_bus_model

// ---- dv/tb_mmef_core.sv ----
// self-checking bench for the message error flag classifier
`timescale 1ns/1ps
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin \
  err_total++; $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e); \
  end end
module tb_mmef_core;
  // clock, reset and register port
  logic                 i_clk     = 1'b0;
  logic                 i_rstn    = 1'b0;
  logic                 reg_wr    = 1'b0;
  logic                 reg_rd    = 1'b0;
  logic [7:0]           reg_addr  = 8'h00;
  logic [15:0]          reg_wdata = 16'h0000;
  // bus words and results
  logic                 word_vld, sync_det, msg_end;
  mmef_pkg::mmef_word_t word;
  logic [15:0]          o_reg_rdata, o_msg_status;
  logic                 o_msg_done, o_irq;
  // bookkeeping
  int                   err_total    = 0;
  int                   total_checks = 0;
  logic                 gap_on       = 1'b0;
  logic [15:0]          rnd          = 16'h0052;
  logic [15:0]          c1, c2;
  // second commands for pair corners; last one goes with a sync error
  logic [15:0] c2_tab [6] = '{16'h1443, 16'h1043, 16'h1403,
                              16'h17E3, 16'h0C43, 16'h1443};
  // single commands around the content checks, last defined code
  logic [15:0] ct_tab [6] = '{16'hFC20, 16'hFFC0, 16'h0805,
                              16'hFFE2, 16'hFC00, 16'hFFF1};

  always #10 i_clk = ~i_clk;

  mmef_core u_dut (
    .i_clk(i_clk), .i_rstn(i_rstn),
    .i_word_vld(word_vld), .i_word(word),
    .i_sync_det(sync_det), .i_msg_end(msg_end),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_msg_done(o_msg_done),
    .o_msg_status(o_msg_status), .o_irq(o_irq)
  );
  mmef_bus_model u_bus (
    .i_clk(i_clk), .o_word_vld(word_vld), .o_word(word),
    .o_sync_det(sync_det), .o_msg_end(msg_end)
  );

  // ------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // mode subaddress test
  function automatic logic md(input logic [15:0] w);
    return w[9:5] == 5'h00 || w[9:5] == 5'h1F;
  endfunction : md
  // broadcast transmit non-mode or undefined code; rx undefined code
  function automatic logic cont(input logic [15:0] w);
    return (w[15:11] == 5'h1F && w[10] && (!md(w) || !w[4]))
        || (!w[10] && md(w) && !w[4]);
  endfunction : cont
  // illogical second command of a pair
  function automatic logic cw2(input logic [15:0] a, input logic [15:0] b);
    return !b[10] || md(b) || b[15:11] == a[15:11];
  endfunction : cw2

  // ------------------------------------------------------------
  // register port and message tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge i_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask : rd
  // command(s), responses, idle; then compare the stored status
  task automatic msg(input logic [15:0] a, input logic [15:0] b,
                     input logic pr, input logic [3:0] be,
                     input logic [3:0] se, input int sg,
                     input logic [4:0] bad, input logic [15:0] mk);
    logic [3:0]  f;
    logic [15:0] ex;
    int          n;
    f[0] = cont(a) | (pr & cont(b));
    f[1] = pr & (cw2(a, b) | be[3]);
    f[2] = pr & ((gap_on & sg < 200) | (|se) | (|bad));
    f[3] = |se[2:0];
    ex = {4'h0, pr, 2'b00, ~|f, 4'h0, f};
    u_bus.send(1'b1, 4'h0, a, 50);
    if (pr) u_bus.send(1'b1, be, b, 50);
    u_bus.send(1'b1, se, {(pr ? b[15:11] : a[15:11]) ^ bad, 11'h000}, sg);
    if (pr) u_bus.send(1'b1, 4'h0, {a[15:11], 11'h000}, 250);
    u_bus.finish_msg();
    // done stands one cycle from the edge that took the end strobe
    n = 0;
    #1;
    while (o_msg_done !== 1'b1 && n < 40) begin
      @(posedge i_clk);
      #1 n++;
    end
    `CHK(o_msg_done, 1'b1, "done")
    `CHK(o_msg_status & mk, ex & mk, "status")
  endtask : msg

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin : main
    logic [15:0] d;
    int          k;
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    // reset values, unmapped place, enable readback
    rd(8'h00, d); `CHK(d, 16'h0000, "cfg reset")
    rd(8'h10, d); `CHK(d, 16'h0000, "en reset")
    rd(8'h40, d); `CHK(d, 16'h0000, "unmapped")
    wr(8'h10, 16'h0003);
    rd(8'h10, d); `CHK(d, 16'h0003, "en")
    $display("test registers done");
    // parity, bit count, manchester on a response
    for (k = 0; k < 3; k++) begin
      msg(16'h0823, 16'h0000, 1'b0, 4'h0, 4'h1 << k, 250, 5'h00,
          16'hFFFF);
    end
    `CHK(o_irq, 1'b1, "irq raised")
    rd(8'h08, d); `CHK(d, 16'h0003, "irq status")
    wr(8'h0C, 16'h0001);
    `CHK(o_irq, 1'b1, "irq err left")
    wr(8'h0C, 16'h0002);
    `CHK(o_irq, 1'b0, "irq cleared")
    wr(8'h04, 16'hFFFF);
    rd(8'h04, d); `CHK(d, 16'h0008, "last read only")
    $display("test word errors done");
    // pair corners with gap checking on and off
    wr(8'h00, 16'h1000);
    gap_on = 1'b1;
    rd(8'h00, d); `CHK(d, 16'h1000, "cfg")
    msg(16'h0843, 16'h1443, 1'b1, 4'h0, 4'h0, 200, 5'h00, 16'hFFFF);
    msg(16'h0843, 16'h1443, 1'b1, 4'h0, 4'h0, 199, 5'h00, 16'hFFFF);
    wr(8'h00, 16'h0000);
    gap_on = 1'b0;
    msg(16'h0843, 16'h1443, 1'b1, 4'h0, 4'h0, 180, 5'h00, 16'hFFFF);
    msg(16'h0843, 16'h1443, 1'b1, 4'h0, 4'h1, 250, 5'h00, 16'hFFFF);
    msg(16'h0843, 16'h1443, 1'b1, 4'h0, 4'h0, 250, 5'h04, 16'hFFFF);
    for (k = 1; k < 6; k++) begin
      msg(16'h0843, c2_tab[k], 1'b1, (k == 5) ? 4'h8 : 4'h0, 4'h0, 250,
          5'h00, (k == 5) ? 16'h0802 : 16'hFFFF);
    end
    $display("test pair corners done");
    for (k = 0; k < 6; k++) begin
      msg(ct_tab[k], 16'h0000, 1'b0, 4'h0, 4'h0, 250, 5'h00,
          16'hFFFF);
    end
    $display("test content done");
    // random commands, some pairs aimed at one terminal
    for (k = 0; k < 24; k++) begin
      rnd = lfsr(rnd);
      c1 = rnd;
      rnd = lfsr(rnd);
      c2 = rnd;
      if (k % 4 == 0) c2[15:11] = c1[15:11];
      msg(c1, c2, rnd[0], 4'h0, 4'h0, 250, 5'h00, 16'hFFFF);
    end
    $display("test random done");
    final_report();
  end

  // hang guard, well beyond the expected run
  initial begin : watchdog
    repeat (80000) @(posedge i_clk);
    err_total++;
    final_report();
  end
endmodule : tb_mmef_core
